// ### hw/cpu_map_pkg.sv
/*
  Package for the CPU register bank and data map block: address windows,
  relocation operands, reset values, access widths and request carriers.
  Assumes a single 200 MHz core clock and one asynchronous reset.
*/
package cpu_map_pkg;

  // ----------------------------------------------------------------------
  // Address space and data area windows
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam logic [3:0] LOW_PAGE = 4'h0;
  localparam logic [3:0] HIGH_PAGE = 4'hF;
  localparam logic [15:0] DATA_FIRST = 16'hF700;
  localparam logic [15:0] DATA_LAST = 16'hFFFF;
  // General register banks live inside internal RAM, just below the SFRs
  localparam logic [15:0] REGS_FIRST = 16'hFE80;
  localparam logic [15:0] REGS_LAST = 16'hFEFF;

  // ----------------------------------------------------------------------
  // Relocation operands
  // ----------------------------------------------------------------------
  localparam logic [7:0] RELOC_OP_LOW = 8'h00;
  localparam logic [7:0] RELOC_OP_HIGH = 8'h0F;

  // ----------------------------------------------------------------------
  // Register file shape and reset values
  // ----------------------------------------------------------------------
  localparam int BANKS = 8;
  localparam int REGS_PER_BANK = 16;
  localparam int GPR_BYTES = BANKS * REGS_PER_BANK;
  localparam int EXT_REGS = BANKS * 4;
  localparam logic [7:0] GPR_RESET = 8'h00;
  localparam logic [2:0] BANK_RESET = 3'h0;
  localparam logic [19:0] PC_RESET = 20'h00000;
  localparam logic [23:0] SP_RESET = 24'h000000;

  // Access widths of the register port
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_24 = 2'h2;

  typedef enum logic [1:0] {MAP_UNSET, MAP_LOW, MAP_HIGH} map_state_t;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] width;
    logic legacy;
    logic [3:0] index;
    logic [23:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [23:0] rdata;
  } reg_rsp_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [19:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic ack;
    logic area_hit;
    logic regs_hit;
    logic [7:0] rdata;
  } mem_rsp_t;

endpackage

// ### hw/addr_window.sv
/*
  Combinational window decoder: tells whether a 20-bit address falls in a
  16-bit range placed on the low or the high 64K page, and its offset.
  Assumes the caller gates the hit with its own notion of validity.
*/
`timescale 1ns/1ps
module addr_window #(
  parameter logic [15:0] FIRST = 16'h0000,
  parameter logic [15:0] LAST = 16'hFFFF
) (
  input wire logic [19:0] addr_in,
  input wire logic high_in,
  output logic hit_out,
  output logic [15:0] offset_out
);
  import cpu_map_pkg::*;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // Page nibble picks the window, low half compares against the range
  always_comb
  begin
    hit_out = (addr_in[19:16] == (high_in ? HIGH_PAGE : LOW_PAGE)) &&
              (addr_in[15:0] >= FIRST) && (addr_in[15:0] <= LAST);
    offset_out = addr_in[15:0] - FIRST;
  end

endmodule

// ### hw/cpu_register_bank_and_data_map.sv
/*
  CPU register bank and data map: one-time relocation of the internal data
  area, eight banks of sixteen byte registers held in internal RAM, pair
  and pointer views, legacy alias names, program counter, stack pointer.
  Assumes the instruction sequencer drives the request ports synchronously.
*/
// Function
// - One megabyte combined space addressed with 20-bit addresses.
// - Relocate operand zero maps data area at 0F700H to 0FFFFH.
// - Relocate operand 0FH maps data area at FF700H to FFFFFH.
// - Each bank holds sixteen 8-bit general registers.
// - Adjacent byte registers also read and write as a 16-bit pair.
// - Four pairs join an 8-bit extension register as 24-bit pointers.
// - Eight banks; software or context switch selects the active one.
// - General registers live in internal RAM; extension registers do not.
// - Alias bit set lets legacy names reach R4 to R7, pairs 2 and 3.
// - Program counter is 20 bits and advances as instructions execute.
// - Stack pointer is 24 bits holding the first stack address.
`timescale 1ns/1ps
module cpu_register_bank_and_data_map (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic data_area_relocate_instruction_in,
  input wire logic [7:0] reloc_operand_in,
  input wire logic legacy_alias_select_bit_in,
  input wire logic bank_write_in,
  input wire logic [2:0] bank_sel_in,
  input wire logic ctx_switch_in,
  input wire logic [2:0] ctx_bank_in,
  input wire cpu_map_pkg::reg_req_t reg_req_in,
  input wire cpu_map_pkg::mem_req_t mem_req_in,
  input wire logic pc_load_in,
  input wire logic [19:0] pc_target_in,
  input wire logic [2:0] pc_advance_in,
  input wire logic sp_write_in,
  input wire logic [23:0] sp_wdata_in,
  output cpu_map_pkg::reg_rsp_t reg_rsp_out,
  output cpu_map_pkg::mem_rsp_t mem_rsp_out,
  output cpu_map_pkg::map_state_t map_state_out,
  output logic reloc_error_out,
  output logic [2:0] bank_out,
  output logic [19:0] instruction_pointer_out,
  output logic [23:0] stack_pointer_out
);
  import cpu_map_pkg::*;

  // ----------------------------------------------------------------------
  // Storage and next values
  // ----------------------------------------------------------------------
  logic [7:0] gpr [0:GPR_BYTES-1];
  logic [7:0] next_gpr [0:GPR_BYTES-1];
  logic [7:0] ext [0:EXT_REGS-1];
  logic [7:0] next_ext [0:EXT_REGS-1];
  map_state_t map_state, next_map_state;
  logic reloc_error, next_reloc_error;
  logic [2:0] bank, next_bank;
  logic [19:0] pc, next_pc;
  logic [23:0] sp, next_sp;
  reg_rsp_t reg_rsp, next_reg_rsp;
  mem_rsp_t mem_rsp, next_mem_rsp;

  // Request decode
  logic req_ok;
  logic [3:0] byte_sel;
  logic [2:0] pair_sel;
  logic [6:0] lo_idx;
  logic [6:0] hi_idx;
  logic [4:0] ext_idx;
  logic [23:0] req_rdata;
  logic map_on;
  logic map_high;
  logic area_hit;
  logic regs_hit;
  logic [15:0] area_offset;
  logic [15:0] regs_offset;
  logic [6:0] mem_idx;

  // ----------------------------------------------------------------------
  // Data area relocation
  // ----------------------------------------------------------------------
  // Only the first relocation with a known operand after reset counts; a repeat or an unknown
  // operand leaves the map alone and raises a sticky error until reset.
  always_comb
  begin
    next_map_state = map_state;
    next_reloc_error = reloc_error;
    if (data_area_relocate_instruction_in)
    begin
      if (map_state != MAP_UNSET)
        next_reloc_error = 1'b1;
      else if (reloc_operand_in == RELOC_OP_LOW)
        next_map_state = MAP_LOW;
      else if (reloc_operand_in == RELOC_OP_HIGH)
        next_map_state = MAP_HIGH;
      else
        next_reloc_error = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      map_state <= MAP_UNSET;
      reloc_error <= 1'b0;
    end
    else
    begin
      map_state <= next_map_state;
      reloc_error <= next_reloc_error;
    end
  end

  // ----------------------------------------------------------------------
  // Address windows
  // ----------------------------------------------------------------------
  // Until relocation runs nothing internal decodes, so stray accesses
  // go outside rather than landing in a guessed window.
  assign map_on = (map_state != MAP_UNSET);
  assign map_high = (map_state == MAP_HIGH);

  addr_window #(
    .FIRST(DATA_FIRST),
    .LAST(DATA_LAST)
  ) u_area_window (
    .addr_in(mem_req_in.addr),
    .high_in(map_high),
    .hit_out(area_hit),
    .offset_out(area_offset)
  );

  addr_window #(
    .FIRST(REGS_FIRST),
    .LAST(REGS_LAST)
  ) u_regs_window (
    .addr_in(mem_req_in.addr),
    .high_in(map_high),
    .hit_out(regs_hit),
    .offset_out(regs_offset)
  );

  assign mem_idx = regs_offset[6:0];

  // ----------------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------------
  // Legacy names are honoured only while the alias bit is set; otherwise
  // such a request is refused instead of hitting a random register.
  always_comb
  begin
    req_ok = 1'b1;
    byte_sel = reg_req_in.index;
    pair_sel = reg_req_in.index[2:0];
    if (reg_req_in.legacy)
    begin
      if (!legacy_alias_select_bit_in)
        req_ok = 1'b0;
      if (reg_req_in.width == WIDTH_8)
      begin
        byte_sel = {2'h1, reg_req_in.index[1:0]};
        if (reg_req_in.index[3:2] != 2'h0)
          req_ok = 1'b0;
      end
      else if (reg_req_in.width == WIDTH_16)
      begin
        pair_sel = {2'h1, reg_req_in.index[0]};
        if (reg_req_in.index[3:1] != 3'h0)
          req_ok = 1'b0;
      end
      else
        req_ok = 1'b0;
    end
    else if (reg_req_in.width == WIDTH_16)
    begin
      if (reg_req_in.index[3])
        req_ok = 1'b0;
    end
    else if (reg_req_in.width == WIDTH_24)
    begin
      pair_sel = {1'b1, reg_req_in.index[1:0]};
      if (reg_req_in.index[3:2] != 2'h0)
        req_ok = 1'b0;
    end
    else if (reg_req_in.width != WIDTH_8)
      req_ok = 1'b0;
  end

  // Byte address inside the register RAM is bank then register
  always_comb
  begin
    if (reg_req_in.width == WIDTH_8)
      lo_idx = {bank, byte_sel};
    else
      lo_idx = {bank, pair_sel, 1'b0};
    hi_idx = {lo_idx[6:1], 1'b1};
    ext_idx = {bank, pair_sel[1:0]};
    if (reg_req_in.width == WIDTH_8)
      req_rdata = {16'h0000, gpr[lo_idx]};
    else if (reg_req_in.width == WIDTH_16)
      req_rdata = {8'h00, gpr[hi_idx], gpr[lo_idx]};
    else
      req_rdata = {ext[ext_idx], gpr[hi_idx], gpr[lo_idx]};
  end

  // ----------------------------------------------------------------------
  // Register RAM and extension registers
  // ----------------------------------------------------------------------
  // The general registers are bytes of internal RAM, so a data access to
  // the register window reaches the same cells. The register port wins
  // when both write one byte in the same cycle.
  always_comb
  begin
    next_gpr = gpr;
    next_ext = ext;
    if (mem_req_in.wr && map_on && regs_hit)
      next_gpr[mem_idx] = mem_req_in.wdata;
    if (reg_req_in.valid && reg_req_in.write && req_ok)
    begin
      next_gpr[lo_idx] = reg_req_in.wdata[7:0];
      if (reg_req_in.width != WIDTH_8)
        next_gpr[hi_idx] = reg_req_in.wdata[15:8];
      if (reg_req_in.width == WIDTH_24)
        next_ext[ext_idx] = reg_req_in.wdata[23:16];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < GPR_BYTES; i++)
        gpr[i] <= GPR_RESET;
      for (int i = 0; i < EXT_REGS; i++)
        ext[i] <= GPR_RESET;
    end
    else
    begin
      gpr <= next_gpr;
      ext <= next_ext;
    end
  end

  // ----------------------------------------------------------------------
  // Responses
  // ----------------------------------------------------------------------
  // Reads return the value before any write of the same cycle
  always_comb
  begin
    next_reg_rsp.ack = reg_req_in.valid;
    next_reg_rsp.err = reg_req_in.valid && !req_ok;
    next_reg_rsp.rdata = 24'h000000;
    if (reg_req_in.valid && !reg_req_in.write && req_ok)
      next_reg_rsp.rdata = req_rdata;
    next_mem_rsp.ack = mem_req_in.rd || mem_req_in.wr;
    next_mem_rsp.area_hit = map_on && area_hit;
    next_mem_rsp.regs_hit = map_on && regs_hit;
    next_mem_rsp.rdata = 8'h00;
    if (mem_req_in.rd && map_on && regs_hit)
      next_mem_rsp.rdata = gpr[mem_idx];
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      reg_rsp <= '0;
      mem_rsp <= '0;
    end
    else
    begin
      reg_rsp <= next_reg_rsp;
      mem_rsp <= next_mem_rsp;
    end
  end

  // ----------------------------------------------------------------------
  // Bank select, program counter and stack pointer
  // ----------------------------------------------------------------------
  // A context switch outranks a software bank write in the same cycle,
  // since the interrupt must land in its own bank.
  always_comb
  begin
    next_bank = bank;
    if (ctx_switch_in)
      next_bank = ctx_bank_in;
    else if (bank_write_in)
      next_bank = bank_sel_in;
    next_pc = pc;
    if (pc_load_in)
      next_pc = pc_target_in;
    else
      next_pc = pc + {17'h00000, pc_advance_in};
    next_sp = sp;
    if (sp_write_in)
      next_sp = sp_wdata_in;
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      bank <= BANK_RESET;
      pc <= PC_RESET;
      sp <= SP_RESET;
    end
    else
    begin
      bank <= next_bank;
      pc <= next_pc;
      sp <= next_sp;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rsp_out = reg_rsp;
  assign mem_rsp_out = mem_rsp;
  assign map_state_out = map_state;
  assign reloc_error_out = reloc_error;
  assign bank_out = bank;
  assign instruction_pointer_out = pc;
  assign stack_pointer_out = sp; // Upper nibble kept as written

endmodule

// ### bench/cpu_map_checker.sv
/*
  Checker for the register bank and data map: answer timing, pointer
  updates, relocation. Assumes it is bound to the top module's ports.
*/
`timescale 1ns/1ps
module cpu_map_checker (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic data_area_relocate_instruction_in,
  input wire logic [7:0] reloc_operand_in,
  input wire logic ctx_switch_in,
  input wire logic [2:0] ctx_bank_in,
  input wire cpu_map_pkg::reg_req_t reg_req_in,
  input wire cpu_map_pkg::mem_req_t mem_req_in,
  input wire logic pc_load_in,
  input wire logic [2:0] pc_advance_in,
  input wire logic sp_write_in,
  input wire logic [23:0] sp_wdata_in,
  input wire cpu_map_pkg::reg_rsp_t reg_rsp_out,
  input wire cpu_map_pkg::mem_rsp_t mem_rsp_out,
  input wire cpu_map_pkg::map_state_t map_state_out,
  input wire logic reloc_error_out,
  input wire logic [2:0] bank_out,
  input wire logic [19:0] instruction_pointer_out,
  input wire logic [23:0] stack_pointer_out
);
  import cpu_map_pkg::*;
  // ------------------------------------------------------------
  // Properties on the core clock
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  // Short name for the relocation pulse
  wire reloc = data_area_relocate_instruction_in;

  reg_ack_a: assert property (reg_req_in.valid |=> reg_rsp_out.ack)
    else $error("register request not answered");
  mem_ack_a: assert property (mem_req_in.rd |=> mem_rsp_out.ack)
    else $error("memory read not answered");
  // Sampled reset keeps the release edge out, where pc still holds
  pc_step_a: assert property (rstn_in && !pc_load_in |=>
    instruction_pointer_out == 20'($past(instruction_pointer_out)
    + $past(pc_advance_in))) else $error("pc did not advance");
  sp_write_a: assert property (sp_write_in |=>
    stack_pointer_out == $past(sp_wdata_in)) else $error("sp not written");
  ctx_bank_a: assert property (ctx_switch_in |=>
    bank_out == $past(ctx_bank_in)) else $error("context bank missed");
  reloc_lo_a: assert property (reloc && map_state_out == MAP_UNSET
    && reloc_operand_in == RELOC_OP_LOW |=> map_state_out == MAP_LOW)
    else $error("low map not set");
  reloc_hi_a: assert property (reloc && map_state_out == MAP_UNSET
    && reloc_operand_in == RELOC_OP_HIGH |=> map_state_out == MAP_HIGH)
    else $error("high map not set");
  reloc_once_a: assert property (reloc && map_state_out != MAP_UNSET
    |=> reloc_error_out && $stable(map_state_out))
    else $error("repeat relocation not refused");
  width_err_a: assert property (reg_req_in.valid
    && reg_req_in.width == 2'h3 |=> reg_rsp_out.err)
    else $error("illegal width accepted");
  mem_none_a: assert property (mem_req_in.rd
    && map_state_out == MAP_UNSET |=> !mem_rsp_out.area_hit)
    else $error("decode before relocation");
endmodule

bind cpu_register_bank_and_data_map cpu_map_checker u_cpu_map_checker (.*);

// ### bench/test_cpu_register_bank_and_data_map.sv
/*
  Self-checking bench for the register bank and data map block.
  Assumes the checker file is compiled alongside and binds itself.
*/
`timescale 1ns/1ps
module test_cpu_register_bank_and_data_map;
  import cpu_map_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic data_area_relocate_instruction_in = 1'b0;
  logic [7:0] reloc_operand_in = 8'h00;
  logic legacy_alias_select_bit_in = 1'b0;
  logic bank_write_in = 1'b0;
  logic [2:0] bank_sel_in = 3'h0;
  logic ctx_switch_in = 1'b0;
  logic [2:0] ctx_bank_in = 3'h0;
  reg_req_t reg_req_in = '0;
  mem_req_t mem_req_in = '0;
  logic pc_load_in = 1'b0;
  logic [19:0] pc_target_in = 20'h00000;
  logic [2:0] pc_advance_in = 3'h1;
  logic sp_write_in = 1'b0;
  logic [23:0] sp_wdata_in = 24'h000000;
  reg_rsp_t reg_rsp_out;
  mem_rsp_t mem_rsp_out;
  map_state_t map_state_out;
  logic reloc_error_out;
  logic [2:0] bank_out;
  logic [19:0] instruction_pointer_out;
  logic [23:0] stack_pointer_out;
  int error_cnt = 0;
  int tests_run = 0;
  reg_rsp_t rr;
  mem_rsp_t mr;

  cpu_register_bank_and_data_map u_cpu_register_bank_and_data_map (.*);

  // ------------------------------------------------------------
  // Clock, checks and bus tasks
  // ------------------------------------------------------------
  always #2.5 clk_in = ~clk_in;

  task automatic chk(input string n, input logic [23:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic do_reset;
    @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
  endtask

  // Answers are fixed at one cycle, so no polling is needed
  task automatic reg_op(input logic w, input logic [1:0] wd,
    input logic lg, input logic [3:0] ix, input logic [23:0] d);
    @(posedge clk_in);
    reg_req_in <= '{1'b1, w, wd, lg, ix, d};
    @(posedge clk_in);
    reg_req_in <= '0;
    #1 rr = reg_rsp_out;
    chk("reg ack", rr.ack, 1'b1);
  endtask

  task automatic mem_op(input logic w, input logic [19:0] a,
    input logic [7:0] d);
    @(posedge clk_in);
    mem_req_in <= '{!w, w, a, d};
    @(posedge clk_in);
    mem_req_in <= '0;
    #1 mr = mem_rsp_out;
    chk("mem ack", mr.ack, 1'b1);
  endtask

  task automatic reloc(input logic [7:0] op);
    @(posedge clk_in);
    data_area_relocate_instruction_in <= 1'b1;
    reloc_operand_in <= op;
    @(posedge clk_in);
    data_area_relocate_instruction_in <= 1'b0;
    #1;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Window edges are probed at both ends of the area and one byte below it
  task automatic t_low;
    mem_op(1'b0, 20'h0FE85, 8'h00);
    chk("unmapped", mr.area_hit, 1'b0);
    reloc(RELOC_OP_LOW);
    chk("map low", map_state_out, MAP_LOW);
    chk("no error", reloc_error_out, 1'b0);
    mem_op(1'b0, 20'h0F700, 8'h00);
    chk("low first", mr.area_hit, 1'b1);
    chk("not regs", mr.regs_hit, 1'b0);
    mem_op(1'b0, 20'h0FFFF, 8'h00);
    chk("low last", mr.area_hit, 1'b1);
    mem_op(1'b0, 20'h0F6FF, 8'h00);
    chk("below area", mr.area_hit, 1'b0);
    mem_op(1'b0, 20'hFFFFF, 8'h00);
    chk("high page", mr.area_hit, 1'b0);
    reloc(RELOC_OP_HIGH);
    chk("second reloc", reloc_error_out, 1'b1);
    chk("map kept", map_state_out, MAP_LOW);
  endtask

  task automatic t_regs;
    reg_op(1'b1, WIDTH_8, 1'b0, 4'h4, 24'h000011);
    reg_op(1'b1, WIDTH_8, 1'b0, 4'h5, 24'h000022);
    reg_op(1'b0, WIDTH_16, 1'b0, 4'h2, 24'h0);
    chk("pair 2", rr.rdata[15:0], 16'h2211);
    reg_op(1'b1, WIDTH_24, 1'b0, 4'h0, 24'hABCDEF);
    reg_op(1'b0, WIDTH_8, 1'b0, 4'h9, 24'h0);
    chk("ptr byte", rr.rdata[7:0], 8'hCD);
    reg_op(1'b0, WIDTH_24, 1'b0, 4'h0, 24'h0);
    chk("pointer 0", rr.rdata, 24'hABCDEF);
    reg_op(1'b0, WIDTH_16, 1'b0, 4'h8, 24'h0);
    chk("pair range", rr.err, 1'b1);
    mem_op(1'b0, 20'h0FE88, 8'h00);
    chk("ram view", mr.rdata, 8'hEF);
    chk("regs hit", mr.regs_hit, 1'b1);
    mem_op(1'b1, 20'h0FE8F, 8'h5C);
    reg_op(1'b0, WIDTH_8, 1'b0, 4'hF, 24'h0);
    chk("ram write", rr.rdata[7:0], 8'h5C);
    reg_op(1'b0, 2'h3, 1'b0, 4'h0, 24'h0);
    chk("bad width", rr.err, 1'b1);
  endtask

  task automatic t_legacy;
    reg_op(1'b0, WIDTH_8, 1'b1, 4'h1, 24'h0);
    chk("alias off", rr.err, 1'b1);
    @(posedge clk_in);
    legacy_alias_select_bit_in <= 1'b1;
    reg_op(1'b0, WIDTH_8, 1'b1, 4'h1, 24'h0);
    chk("legacy A", rr.rdata[7:0], 8'h22);
    reg_op(1'b0, WIDTH_16, 1'b1, 4'h0, 24'h0);
    chk("legacy AX", rr.rdata[15:0], 16'h2211);
  endtask

  // Both bank sources in one cycle: the context switch must win
  task automatic t_bank;
    @(posedge clk_in);
    bank_write_in <= 1'b1;
    bank_sel_in <= 3'h3;
    @(posedge clk_in);
    bank_write_in <= 1'b0;
    #1 chk("sw bank", bank_out, 3'h3);
    reg_op(1'b1, WIDTH_8, 1'b0, 4'h0, 24'h00005A);
    @(posedge clk_in);
    ctx_switch_in <= 1'b1;
    ctx_bank_in <= 3'h5;
    bank_write_in <= 1'b1;
    bank_sel_in <= 3'h6;
    @(posedge clk_in);
    ctx_switch_in <= 1'b0;
    bank_write_in <= 1'b0;
    #1 chk("ctx wins", bank_out, 3'h5);
    reg_op(1'b0, WIDTH_8, 1'b0, 4'h0, 24'h0);
    chk("bank5 R0", rr.rdata[7:0], 8'h00);
    mem_op(1'b0, 20'h0FEB0, 8'h00);
    chk("bank3 ram", mr.rdata, 8'h5A);
  endtask

  task automatic t_ptrs;
    @(posedge clk_in);
    pc_load_in <= 1'b1;
    pc_target_in <= 20'hFFFFE;
    sp_write_in <= 1'b1;
    sp_wdata_in <= 24'h0FEDCB;
    @(posedge clk_in);
    pc_load_in <= 1'b0;
    sp_write_in <= 1'b0;
    pc_advance_in <= 3'h3;
    #1 chk("pc load", instruction_pointer_out, 20'hFFFFE);
    chk("sp", stack_pointer_out, 24'h0FEDCB);
    repeat (2) @(posedge clk_in);
    #1 chk("pc wrap", instruction_pointer_out, 20'h00004);
  endtask

  task automatic t_high;
    do_reset;
    reloc(RELOC_OP_HIGH);
    chk("map high", map_state_out, MAP_HIGH);
    chk("error reset", reloc_error_out, 1'b0);
    mem_op(1'b1, 20'hFFE81, 8'h77);
    reg_op(1'b0, WIDTH_8, 1'b0, 4'h1, 24'h0);
    chk("high ram", rr.rdata[7:0], 8'h77);
    mem_op(1'b0, 20'h0FE81, 8'h00);
    chk("old window", mr.area_hit, 1'b0);
    mem_op(1'b0, 20'hFF700, 8'h00);
    chk("high first", mr.area_hit, 1'b1);
    mem_op(1'b0, 20'hFFFFF, 8'h00);
    chk("high last", mr.area_hit, 1'b1);
  endtask

  initial
  begin
    do_reset;
    #1 chk("reset map", map_state_out, MAP_UNSET);
    chk("reset sp", stack_pointer_out, 24'h0);
    t_low;
    t_regs;
    t_legacy;
    t_bank;
    t_ptrs;
    t_high;
    wrap_up;
  end

  // Watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    wrap_up;
  end
endmodule
